// [ddrio_cell.sv]
`timescale 1ns/1ns
`include "ddrio_regs.svh"

module ddrio_fifo #(
    parameter int W = 2,
    parameter int D = 32,
    parameter int AW = 5
) (
    input  wire logic         sys_clk,   // system clock
    input  wire logic         resetn,    // async reset, active low
    input  wire logic         in_valid,  // word offered
    output logic              in_ready,  // room for a word
    input  wire logic [W-1:0] in_data,   // word in
    output logic              out_valid, // word available
    input  wire logic         out_ready, // consumer takes word
    output logic [W-1:0]      out_data   // head word
);
    logic [W-1:0] mem [D];
    logic [AW:0]  wptr_r;
    logic [AW:0]  rptr_r;
    logic         push;
    logic         pop;
    // full when pointers differ only in the wrap bit
    assign in_ready  = (wptr_r ^ rptr_r) != {1'b1, {AW{1'b0}}};
    assign out_valid = wptr_r != rptr_r;
    assign out_data  = mem[rptr_r[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // storage carries no reset, only the pointers do
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wptr_r[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wptr_r <= '0;
            rptr_r <= '0;
        end else begin
            if (push) begin
                wptr_r <= wptr_r + 1'b1;
            end
            if (pop) begin
                rptr_r <= rptr_r + 1'b1;
            end
        end
    end
endmodule
module ddrio_cell
    import ddrio_pkg::*;
(
    input  wire logic             sys_clk,            // system clock, 100 MHz
    input  wire logic             resetn,             // async reset, active low
    input  wire logic             pad_input_signal,   // pad input, asynchronous
    input  wire logic             strobe_pin,         // returned read strobe pin
    input  wire logic             read_en,            // core: read window open
    input  wire logic             in_bypass,          // pad straight to core
    output logic                  input_comb_direct,  // bypassed pad level
    output logic                  input_clock_path,   // pad rising edge pulse
    output logic                  rd_valid,           // read pair available
    input  wire logic             rd_ready,           // core takes read pair
    output ddrio_pkg::ddrio_pair_s rd_data,           // read pair
    output logic                  polarity_sel,       // chosen sync phase
    output logic                  read_locked,        // polarity held for burst
    input  wire ddrio_pkg::ddrio_ocfg_s out_cfg,      // output register setup
    input  wire logic             out_data_first,     // output data, first beat
    input  wire logic             out_data_second,    // output data, second beat
    output logic                  pad_output_drive    // to pad buffer
);
    import ddrio_pkg::*;
    logic        pad_s1_r, pad_s2_r, pad_s3_r;
    logic        strb_s1_r, strb_s2_r, strb_s3_r;
    logic        strb_rise, strb_fall;
    ddrio_rd_e   rd_st_r;
    logic        pol_r;
    logic        phase_r;
    logic        cap_first_r;
    ddrio_pair_s pair_r;
    logic        pair_pend_r;
    logic        sync_load;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    ddrio_pair_s fifo_out_data;
    logic        fifo_pop;
    logic        fst_q_r;
    logic        sec_q_r;
    logic        cap_en;
    // two flops on every pin before anything looks at it
    always_ff @(posedge sys_clk or negedge resetn) begin // R02
        if (!resetn) begin
            pad_s1_r  <= 1'b0;
            pad_s2_r  <= 1'b0;
            pad_s3_r  <= 1'b0;
            strb_s1_r <= `DDRIO_STROBE_IDLE;
            strb_s2_r <= `DDRIO_STROBE_IDLE;
            strb_s3_r <= `DDRIO_STROBE_IDLE;
        end else begin
            pad_s1_r  <= pad_input_signal;
            pad_s2_r  <= pad_s1_r;
            pad_s3_r  <= pad_s2_r;
            strb_s1_r <= strobe_pin;
            strb_s2_r <= strb_s1_r;
            strb_s3_r <= strb_s2_r;
        end
    end
    assign strb_rise = strb_s2_r && !strb_s3_r;
    assign strb_fall = !strb_s2_r && strb_s3_r;
    // bypass: level and clock-source edge, no capture registers
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            input_comb_direct <= 1'b0;
            input_clock_path  <= 1'b0;
        end else begin
            input_comb_direct <= in_bypass && pad_s2_r;              // R03
            input_clock_path  <= in_bypass && pad_s2_r && !pad_s3_r; // R03
        end
    end
    // half-rate phase: the divider enable for output and sync loads
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            phase_r <= 1'b0;
        end else begin
            phase_r <= !phase_r;
        end
    end
    // preamble detector; polarity picked fresh for every read
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rd_st_r <= DDRIO_RD_IDLE;
            pol_r   <= 1'b0;
        end else begin
            unique case (rd_st_r)
                DDRIO_RD_IDLE: begin
                    // strobe left at its idle level until the memory pulls it low
                    if (read_en && strb_fall) begin // R11 R12 R13
                        rd_st_r <= DDRIO_RD_PRE;
                        pol_r   <= !phase_r;        // R10 R13
                    end
                end
                DDRIO_RD_PRE: begin
                    if (!read_en) begin
                        rd_st_r <= DDRIO_RD_IDLE;
                    end else if (strb_rise) begin
                        rd_st_r <= DDRIO_RD_BURST;
                    end
                end
                DDRIO_RD_BURST: begin
                    // pol_r untouched until the window closes
                    if (!read_en) begin // R14
                        rd_st_r <= DDRIO_RD_IDLE;
                    end
                end
                default: begin
                    rd_st_r <= DDRIO_RD_IDLE;
                end
            endcase
        end
    end
    assign cap_en = (rd_st_r == DDRIO_RD_BURST) || (rd_st_r == DDRIO_RD_PRE && strb_rise);
    // capture a pair on strobe edges; a held pair blocks the second beat of the next one, not its first
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pair_r      <= '0;
            pair_pend_r <= 1'b0;
            cap_first_r <= 1'b0;
        end else begin
            if (!read_en) begin
                cap_first_r <= 1'b0;
            end else if (cap_en && strb_rise) begin
                pair_r.first <= pad_s2_r;
                cap_first_r  <= 1'b1;
            end else if (cap_en && strb_fall && cap_first_r && !pair_pend_r) begin
                pair_r.second <= pad_s2_r;
                cap_first_r   <= 1'b0;
                pair_pend_r   <= 1'b1;
            end
            if (sync_load) begin
                pair_pend_r <= 1'b0;
            end
        end
    end
    // load only on the chosen phase; fifo full stalls the transfer
    assign sync_load = pair_pend_r && (phase_r == pol_r) && fifo_in_ready; // R09
    ddrio_fifo #(
        .W  (`DDRIO_FIFO_WIDTH),
        .D  (`DDRIO_FIFO_DEPTH),
        .AW (`DDRIO_FIFO_AW)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .in_valid  (pair_pend_r && (phase_r == pol_r)),
        .in_ready  (fifo_in_ready),
        .in_data   (pair_r),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data)
    );
    assign fifo_pop = fifo_out_valid && (!rd_valid || rd_ready);
    // registered read port so core outputs come from flops
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rd_valid <= 1'b0;
            rd_data  <= '0;
        end else if (!rd_valid || rd_ready) begin
            rd_valid <= fifo_out_valid;
            rd_data  <= fifo_out_data;
        end
    end
    // status flops
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            polarity_sel <= 1'b0;
            read_locked  <= 1'b0;
        end else begin
            polarity_sel <= pol_r;
            read_locked  <= rd_st_r != DDRIO_RD_IDLE;
        end
    end
    // single-rate register, shared as first beat in double rate
    always_ff @(posedge sys_clk or negedge resetn) begin // R04
        if (!resetn) begin
            fst_q_r <= 1'b0;
        end else if (out_cfg.rst) begin // R07
            fst_q_r <= 1'b0;
        end else if (out_cfg.ce) begin  // R07
            // latch is open through the high phase, flop loads at its start
            if (!out_cfg.ddr_en && out_cfg.sdr_latch) begin // R05
                if (phase_r) begin
                    fst_q_r <= out_data_first;
                end
            end else if (!phase_r) begin // R05 R06
                fst_q_r <= out_data_first;
            end
        end
    end
    // extra double-rate register: no reset, no enable, by design
    always_ff @(posedge sys_clk) begin // R08
        if (!phase_r) begin
            sec_q_r <= out_data_second; // R06
        end
    end
    // pad mux: first beat the cycle after its load, second the cycle after that
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pad_output_drive <= 1'b0;
        end else if (out_cfg.ddr_en) begin
            pad_output_drive <= phase_r ? fst_q_r : sec_q_r; // R06
        end else begin
            pad_output_drive <= fst_q_r; // R05
        end
    end
    // R01: tristate and control paths reduce here to the phase divider
    property p_pol_hold;
        @(posedge sys_clk) disable iff (!resetn)
        (rd_st_r == DDRIO_RD_BURST) && read_en |=> $stable(pol_r);
    endproperty
    chk_pol_held_burst: assert property (p_pol_hold) // R14
        else $error("polarity changed during burst");
    chk_pol_fresh_read: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (rd_st_r == DDRIO_RD_IDLE) && read_en && strb_fall
        |=> (rd_st_r == DDRIO_RD_PRE) && (pol_r == !$past(phase_r))) // R10 R13
        else $error("polarity not chosen at preamble");
    chk_sync_phase: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        sync_load |-> (phase_r == pol_r) ##1 fifo_out_valid) // R09
        else $error("sync load on wrong phase or lost");
    chk_sync_clears: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        sync_load && !(cap_en && strb_fall) |=> !pair_pend_r) // R09
        else $error("pending pair not transferred");
    chk_bypass_level: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        in_bypass |=> input_comb_direct == $past(pad_s2_r)) // R03
        else $error("bypass level wrong");
    chk_sdr_reset: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        out_cfg.rst ##1 !out_cfg.ddr_en |=> !pad_output_drive) // R07
        else $error("single-rate reset ignored");
    sequence s_ddr_load;
        !phase_r && out_cfg.ddr_en && !out_cfg.rst && out_cfg.ce;
    endsequence
    chk_ddr_first: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        s_ddr_load ##1 out_cfg.ddr_en |=> pad_output_drive == $past(out_data_first, 2)) // R06
        else $error("first beat missing");
    chk_ddr_second: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        !phase_r && out_cfg.ddr_en ##1 out_cfg.ddr_en ##1 out_cfg.ddr_en
        |=> pad_output_drive == $past(out_data_second, 3)) // R06 R08
        else $error("second beat missing");
    chk_sdr_hold_ce: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        !out_cfg.ce && !out_cfg.rst |=> $stable(fst_q_r)) // R07
        else $error("enable did not hold register");
endmodule

// [ddrio_cell_tb_top.sv]
`timescale 1ns/1ns
module ddrio_cell_tb_top;
    import ddrio_pkg::*;
    logic        sys_clk, resetn, read_en, in_bypass, rd_ready;
    logic        first_d, second_d, pol_q, lock_q, strobe, pad;
    logic        comb, ckp, rd_valid, polarity_sel, read_locked, pad_out;
    ddrio_pair_s rd_data;
    ddrio_ocfg_s out_cfg;
    int          err_count, comparisons;
    ddrio_mem_model mem_u (.strobe_pin(strobe), .pad_data(pad));
    ddrio_cell dut_u (
        .sys_clk(sys_clk), .resetn(resetn), .pad_input_signal(pad), .strobe_pin(strobe),
        .read_en(read_en), .in_bypass(in_bypass), .input_comb_direct(comb),
        .input_clock_path(ckp), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
        .polarity_sel(polarity_sel), .read_locked(read_locked), .out_cfg(out_cfg),
        .out_data_first(first_d), .out_data_second(second_d), .pad_output_drive(pad_out));
    // 100 MHz system clock
    always #5 sys_clk = ~sys_clk;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic cfg(input logic [3:0] c, input logic a, input logic b);
        @(posedge sys_clk);
        out_cfg  <= ddrio_ocfg_s'(c);
        first_d  <= a;
        second_d <= b;
        cyc(6);
    endtask
    // double-rate pad must change level every cycle
    task automatic toggles();
        logic p;
        p = pad_out;
        repeat (4) begin
            cyc(1);
            check(pad_out, !p);
            p = pad_out;
        end
    endtask
    task automatic do_read(input ddrio_pair_s a, input ddrio_pair_s b, input int pre);
        int n;
        ddrio_pair_s p [2];
        p[0] = a;
        p[1] = b;
        @(posedge sys_clk) read_en <= 1'b1;
        fork
            mem_u.burst(p, pre);
        join_none
        for (n = 0; n < 40 && read_locked !== 1'b1; n++) cyc(1);
        check(read_locked, 1'b1);
        foreach (p[i]) begin
            for (n = 0; n < 80 && rd_valid !== 1'b1; n++) cyc(1);
            cyc(2);
            check(rd_valid, 1'b1);
            check(rd_data, p[i]);
            @(posedge sys_clk) rd_ready <= 1'b1;
            @(posedge sys_clk) rd_ready <= 1'b0;
            cyc(1);
        end
        wait fork;
        @(posedge sys_clk) read_en <= 1'b0;
        mem_u.release_line();
        cyc(20);
        check(read_locked, 1'b0);
        $display("read test done");
    endtask
    // the chosen phase may not move while a read holds it
    always @(posedge sys_clk) begin
        if (read_locked === 1'b1 && lock_q === 1'b1) check(polarity_sel, pol_q);
        pol_q  <= polarity_sel;
        lock_q <= read_locked;
    end
    // watchdog, far beyond the few microseconds the tests need
    initial begin
        #200000;
        err_count++;
        results();
    end
    initial begin
        sys_clk = 1'b0; resetn = 1'b0; read_en = 1'b0; in_bypass = 1'b0; rd_ready = 1'b0;
        first_d = 1'b0; second_d = 1'b0;
        out_cfg = ddrio_ocfg_s'(4'h0); pol_q = 1'b0; lock_q = 1'b0;
        err_count = 0; comparisons = 0;
        cyc(11);
        check({rd_valid, read_locked, comb, ckp, pad_out}, 8'h00);
        @(posedge sys_clk) resetn <= 1'b1;
        cyc(3);
        // bypass: level after the synchroniser, one clock pulse per rise
        @(posedge sys_clk) in_bypass <= 1'b1;
        mem_u.set_pad(1'b0);
        cyc(6);
        check(comb, 1'b0);
        mem_u.set_pad(1'b1);
        begin
            int k;
            k = 0;
            repeat (8) begin
                cyc(1);
                k += (ckp === 1'b1);
            end
            check(k, 1);
        end
        check(comb, 1'b1);
        @(posedge sys_clk) in_bypass <= 1'b0;
        cyc(6);
        check(comb, 1'b0);
        $display("bypass test done");
        // single rate: flop, hold without enable, reset, latch
        cfg(4'h2, 1'b1, 1'b0);
        check(pad_out, 1'b1);
        cfg(4'h0, 1'b0, 1'b0);
        check(pad_out, 1'b1);
        cfg(4'h1, 1'b1, 1'b0);
        check(pad_out, 1'b0);
        cfg(4'h6, 1'b1, 1'b0);
        check(pad_out, 1'b1);
        // double rate, then reset held on the first beat only
        cfg(4'hA, 1'b1, 1'b0);
        toggles();
        cfg(4'h9, 1'b1, 1'b1);
        toggles();
        $display("output test done");
        do_read(ddrio_pair_s'(2'h2), ddrio_pair_s'(2'h1), 2);
        do_read(ddrio_pair_s'(2'h3), ddrio_pair_s'(2'h0), 3);
        // buffer: two pairs queued behind a stalled reader, drained in order
        begin
            ddrio_pair_s q [2];
            q[0] = ddrio_pair_s'(2'h1);
            q[1] = ddrio_pair_s'(2'h2);
            @(posedge sys_clk) read_en <= 1'b1;
            mem_u.burst(q, 2);
            cyc(10);
            check(read_locked, 1'b1);
            for (int i = 0; i < 2; i++) begin
                check(rd_valid, 1'b1);
                check(rd_data, q[i]);
                @(posedge sys_clk) rd_ready <= 1'b1;
                @(posedge sys_clk) rd_ready <= 1'b0;
                cyc(1);
            end
            check(rd_valid, 1'b0);
            @(posedge sys_clk) read_en <= 1'b0;
            mem_u.release_line();
            cyc(20);
            check(read_locked, 1'b0);
        end
        $display("buffer test done");
        results();
    end
endmodule

// [ddrio_mem_model.sv]
`timescale 1ns/1ns
module ddrio_mem_model
    import ddrio_pkg::*;
(
    output logic strobe_pin, // read strobe, returned with the data
    output logic pad_data    // read data towards the pad
);
    import ddrio_pkg::*;
    // quarter of the 125 ns strobe period, rounded to whole ns
    localparam int Q = 31;
    // released strobe rests high through its termination
    initial begin
        strobe_pin = 1'b1;
        pad_data   = 1'b0;
    end
    // bypass traffic: pad level set by the far side
    task automatic set_pad(input logic v);
        pad_data = v;
    endtask
    // one read: preamble low, then first at rise and second at fall
    task automatic burst(input ddrio_pair_s p [2], input int pre);
        strobe_pin = 1'b0;
        #(pre * 2 * Q);
        foreach (p[i]) begin
            pad_data   = p[i].first;
            #Q;
            strobe_pin = 1'b1;
            #Q;
            pad_data   = p[i].second;
            #Q;
            strobe_pin = 1'b0;
            #Q;
        end
        // data line no longer driven, so it must not keep the last bit
        pad_data = ~pad_data;
    endtask
    // postamble over: strobe back to the termination level
    task automatic release_line();
        strobe_pin = 1'b1;
    endtask
endmodule

// [ddrio_pkg.sv]
package ddrio_pkg;
    // read strobe tracking, gray along idle -> preamble -> burst
    typedef enum logic [1:0] {
        DDRIO_RD_IDLE  = 2'b00,
        DDRIO_RD_PRE   = 2'b01,
        DDRIO_RD_BURST = 2'b11
    } ddrio_rd_e;

    // output register configuration
    typedef struct packed {
        logic ddr_en;     // double-rate output
        logic sdr_latch;  // single-rate element acts as a latch
        logic ce;         // clock enable of the single-rate register
        logic rst;        // synchronous reset of the single-rate register
    } ddrio_ocfg_s;

    // one double-rate pair, first beat in the high bit
    typedef struct packed {
        logic first;
        logic second;
    } ddrio_pair_s;
endpackage

// [ddrio_regs.svh]
`ifndef DDRIO_REGS_SVH
`define DDRIO_REGS_SVH
// How it works
// (R01) cell has input, output, tristate, control paths
// (R02) pad input conditioned by synchronising registers first
// (R03) bypass sends pad straight to core outputs
// (R04) output: one single-rate register plus extra double-rate register
// (R05) single-rate: one element, flip-flop or latch
// (R06) double-rate: rise captures first, mux alternates
// (R07) single-rate register honours reset and clock enable
// (R08) extra double-rate register ignores reset and enable
// (R09) sync register loads on polarity-selected edge
// (R10) polarity chosen again at every read start
// (R11) memory leaves strobe floating before a read
// (R12) memory drives strobe low at preamble start
// (R13) idle-to-low strobe detection sets the polarity
// (R14) polarity held until the read burst ends

// buffer between strobe capture and core
`define DDRIO_FIFO_DEPTH 32
`define DDRIO_FIFO_WIDTH 2
`define DDRIO_FIFO_AW 5
// system clock and the idle level of the read strobe
`define DDRIO_SYS_MHZ 100
`define DDRIO_STROBE_IDLE 1'b1
`endif
